// file: rtl/nis_pkg.sv
// nis_pkg: shared constants for the node interrupt status block.
// assumes a single 50 MHz board clock and a simple shared bus register port.
package nis_pkg;
  localparam int NODES = 4;
  localparam int GROUPS = 3;
  localparam int REG_W = 16;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 6;
  // word index: [5:4] node, [3:2] group, [0] 0 = line status, 1 = condition status
  localparam logic [0:0] SEL_LINE = 1'h0;
  localparam logic [0:0] SEL_COND = 1'h1;
  // bit positions shared by both registers
  localparam int LVL_LO = 0;
  localparam int LVL_HI = 2;
  localparam int BIT_BERR = 3;
  localparam int BIT_DLK = 4;
  localparam int BIT_BRIDGE = 5;
  localparam int BIT_LMON = 6;
  localparam int BIT_EXP0 = 8;
  localparam int BIT_EXP1 = 9;
  localparam int BIT_TOUT = 11;
  localparam int BIT_FLAG0 = 12;
  // write-one-to-clear condition bits
  localparam logic [15:0] COND_W1C = 16'hFB18;
  localparam logic [15:0] LINE_USED = 16'hF367;
  localparam logic [15:0] COND_USED = 16'hFB7F;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // shared bus timeout figures
  localparam int CLK_MHZ = 50;
  localparam int TOUT_SHORT_US = 50;
  localparam int TOUT_LONG_US = 800;
  localparam int TOUT_SHORT_CYC = TOUT_SHORT_US * CLK_MHZ;
  localparam int TOUT_LONG_CYC = TOUT_LONG_US * CLK_MHZ;
  localparam int TOUT_CNT_W = 16;
endpackage

// file: rtl/nis_sync.sv
// nis_sync: two-flop synchroniser for a vector of pin levels.
// assumes inputs are asynchronous to sys_clk; output is two edges late.
module nis_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// file: rtl/nis_top.sv
// nis_top: line status and condition status registers per node and group.
// assumes a one-cycle read/write strobe port on the shared bus; pins are async.
module nis_top #(
  parameter int TOUT_SHORT = nis_pkg::TOUT_SHORT_CYC,
  parameter int TOUT_LONG = nis_pkg::TOUT_LONG_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [nis_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [nis_pkg::BUS_W-1:0] bus_wdata,
  output logic [nis_pkg::BUS_W-1:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [2:0] backplane_level_field,
  input wire logic bridge_chip_irq_n,
  input wire logic location_monitor_line_n,
  input wire logic expansion_line_first_n,
  input wire logic expansion_line_second_n,
  input wire logic [3:0] node_flag_line_n,
  input wire logic backplane_error_flag,
  input wire logic [3:0] node_vme_access,
  input wire logic vme_shared_access,
  input wire logic shared_bus_busy,
  input wire logic shared_bus_ready,
  input wire logic timeout_length_select,
  output logic [nis_pkg::NODES-1:0][nis_pkg::GROUPS-1:0] node_cond_any
);
  localparam int SW = 20;
  localparam int NG = nis_pkg::NODES * nis_pkg::GROUPS;
  // slot of each pin inside the synchroniser vector
  localparam int P_LVL = 0;
  localparam int P_BRG = 3;
  localparam int P_LMON = 4;
  localparam int P_EXP0 = 5;
  localparam int P_EXP1 = 6;
  localparam int P_FLAG = 7;
  localparam int P_BERR = 11;
  localparam int P_VSH = 12;
  localparam int P_BUSY = 13;
  localparam int P_RDY = 14;
  localparam int P_TSEL = 15;
  localparam int P_NVA = 16;

  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic [15:0] live_line;
  logic [15:0] set_evt;
  logic [15:0] flag_q [NG];
  logic [15:0] flag_d [NG];
  logic [11:0] prev_q;
  logic [11:0] prev_d;
  logic [nis_pkg::TOUT_CNT_W-1:0] tcnt_q;
  logic [nis_pkg::TOUT_CNT_W-1:0] tcnt_d;
  logic tout_evt;
  int tlim;
  logic dlk_evt;
  logic [nis_pkg::BUS_W-1:0] rdata_d;
  logic rvalid_d;
  logic [NG-1:0] any_d;
  logic [NG-1:0] any_q;

  function automatic int reg_idx(input logic [nis_pkg::ADDR_W-1:0] a);
    reg_idx = int'(a[5:4]) * nis_pkg::GROUPS + int'(a[3:2]);
  endfunction

  function automatic logic addr_ok(input logic [nis_pkg::ADDR_W-1:0] a);
    addr_ok = (a[3:2] < 2'h3) && (a[1] == 1'h0);
  endfunction

  // active-low lines are flipped before the synchroniser, so all slots read high-true
  always_comb
  begin
    pins_raw = '0;
    pins_raw[P_LVL +: 3] = backplane_level_field;
    pins_raw[P_BRG] = ~bridge_chip_irq_n;
    pins_raw[P_LMON] = ~location_monitor_line_n;
    pins_raw[P_EXP0] = ~expansion_line_first_n;
    pins_raw[P_EXP1] = ~expansion_line_second_n;
    pins_raw[P_FLAG +: 4] = ~node_flag_line_n;
    pins_raw[P_BERR] = backplane_error_flag;
    pins_raw[P_VSH] = vme_shared_access;
    pins_raw[P_BUSY] = shared_bus_busy;
    pins_raw[P_RDY] = shared_bus_ready;
    pins_raw[P_TSEL] = timeout_length_select;
    pins_raw[P_NVA +: 4] = node_vme_access;
  end

  nis_sync #(.W(SW)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // live view shared by every node and group; only gating differs elsewhere
  always_comb
  begin
    live_line = 16'h0000;
    live_line[nis_pkg::LVL_HI:nis_pkg::LVL_LO] = pins_s[2:0];
    live_line[nis_pkg::BIT_BRIDGE] = pins_s[3];
    live_line[nis_pkg::BIT_LMON] = pins_s[4];
    live_line[nis_pkg::BIT_EXP0] = pins_s[5];
    live_line[nis_pkg::BIT_EXP1] = pins_s[6];
    live_line[15:nis_pkg::BIT_FLAG0] = pins_s[10:7];
    live_line = live_line & nis_pkg::LINE_USED;
  end

  // timeout counter; select taken live so a change applies at once, even mid-wait
  always_comb
  begin
    tlim = pins_s[P_TSEL] ? TOUT_LONG : TOUT_SHORT;
    tcnt_d = '0;
    tout_evt = 1'b0;
    if (pins_s[P_BUSY] && !pins_s[P_RDY])
    begin
      // saturate at the limit so one stalled access raises one event
      tcnt_d = tcnt_q;
      if (32'(tcnt_q) < tlim)
        tcnt_d = tcnt_q + 16'h0001;
      if (32'(tcnt_q) == tlim - 1)
        tout_evt = 1'b1;
    end
  end

  // rising edges turn level sources into condition events
  always_comb
  begin
    prev_d = {pins_s[P_BERR], pins_s[10:5], pins_s[4:3],
              pins_s[P_VSH] & |pins_s[P_NVA +: 4], 1'b0, 1'b0};
    dlk_evt = prev_d[2] & ~prev_q[2];
    set_evt = 16'h0000;
    set_evt[nis_pkg::BIT_BERR] = prev_d[11] & ~prev_q[11];
    set_evt[nis_pkg::BIT_DLK] = dlk_evt;
    set_evt[nis_pkg::BIT_TOUT] = tout_evt;
    set_evt[nis_pkg::BIT_EXP0] = prev_d[5] & ~prev_q[5];
    set_evt[nis_pkg::BIT_EXP1] = prev_d[6] & ~prev_q[6];
    set_evt[15:nis_pkg::BIT_FLAG0] = prev_d[10:7] & ~prev_q[10:7];
  end

  // sticky condition flags; set beats a same-cycle clear
  always_comb
  begin
    for (int i = 0; i < NG; i++)
    begin
      flag_d[i] = flag_q[i];
      if (bus_wr && addr_ok(bus_addr) && reg_idx(bus_addr) == i
          && bus_addr[0] == nis_pkg::SEL_COND)
        flag_d[i] = flag_q[i] & ~(bus_wdata[15:0] & nis_pkg::COND_W1C);
      flag_d[i] = (flag_d[i] | set_evt) & nis_pkg::COND_W1C;
      any_d[i] = |flag_d[i] | |live_line[6:0];
    end
  end

  // read mux; condition view merges live level fields with sticky flags
  always_comb
  begin
    rdata_d = '0;
    rvalid_d = bus_rd;
    if (bus_rd && addr_ok(bus_addr))
    begin
      if (bus_addr[0] == nis_pkg::SEL_LINE)
        rdata_d[15:0] = live_line;
      else
        rdata_d[15:0] = (flag_q[reg_idx(bus_addr)]
                        | (live_line & 16'h0067)) & nis_pkg::COND_USED;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      prev_q <= '0;
      tcnt_q <= '0;
      bus_rdata <= '0;
      bus_rvalid <= 1'b0;
      any_q <= '0;
      for (int i = 0; i < NG; i++)
        flag_q[i] <= nis_pkg::REG_RESET;
    end
    else
    begin
      prev_q <= prev_d;
      tcnt_q <= tcnt_d;
      bus_rdata <= rdata_d;
      bus_rvalid <= rvalid_d;
      any_q <= any_d;
      for (int i = 0; i < NG; i++)
        flag_q[i] <= flag_d[i];
    end
  end

  genvar n, g;
  generate
    for (n = 0; n < nis_pkg::NODES; n++)
    begin : g_n
      for (g = 0; g < nis_pkg::GROUPS; g++)
      begin : g_g
        assign node_cond_any[n][g] = any_q[n * nis_pkg::GROUPS + g];
      end
    end
  endgenerate

  timeout_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tout_evt |=> flag_q[0][nis_pkg::BIT_TOUT]) else $error("timeout flag not set");
  w1c_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_wr && bus_addr == 6'h01 && bus_wdata[4] && !set_evt[4]
    |=> !flag_q[0][nis_pkg::BIT_DLK]) else $error("deadlock not cleared");
  zero_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    flag_q[0][12] && !(bus_wr && bus_wdata[12]) |=> flag_q[0][12])
    else $error("flag lost without write one");
  line_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rvalid |-> bus_rdata[31:16] == 16'h0000 && bus_rdata[7] == 1'b0)
    else $error("reserved bits nonzero");
  cond_rsvd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rvalid && $past(bus_addr[0]) |-> bus_rdata[10] == 1'b0)
    else $error("condition bit 10 nonzero");
  level_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && bus_addr[0] == 1'b0 && bus_addr[3:1] == 3'h0
    |=> bus_rdata[2:0] == $past(pins_s[2:0])) else $error("level mismatch");
  exp_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    set_evt[8] |=> flag_q[5][8]) else $error("expansion flag not set");
  berr_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    set_evt[3] |=> flag_q[11][3]) else $error("bus error flag not set");
  // read answers: every read is answered next cycle, unmapped reads give zero, mapped reads mirror the synchronised pins of the request cycle
  rd_answer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd |=> bus_rvalid) else $error("read not answered");
  rd_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !bus_rd |=> !bus_rvalid) else $error("spurious read answer");
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && !addr_ok(bus_addr) |=> bus_rdata == 32'h0000_0000)
    else $error("unmapped read nonzero");
  line_unused_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && addr_ok(bus_addr) && bus_addr[0] == nis_pkg::SEL_LINE
    |=> (bus_rdata[15:0] & ~nis_pkg::LINE_USED) == 16'h0000) else $error("unused line bit");
  line_bridge_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && addr_ok(bus_addr) && bus_addr[0] == nis_pkg::SEL_LINE
    |=> bus_rdata[5] == $past(pins_s[3])) else $error("bridge line mismatch");
  line_monitor_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && addr_ok(bus_addr) && bus_addr[0] == nis_pkg::SEL_LINE
    |=> bus_rdata[6] == $past(pins_s[4])) else $error("monitor line mismatch");
  line_exp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && addr_ok(bus_addr) && bus_addr[0] == nis_pkg::SEL_LINE
    |=> bus_rdata[9:8] == $past(pins_s[6:5])) else $error("expansion line mismatch");
  line_flags_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && addr_ok(bus_addr) && bus_addr[0] == nis_pkg::SEL_LINE
    |=> bus_rdata[15:12] == $past(pins_s[10:7])) else $error("flag line mismatch");
  line_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && addr_ok(bus_addr) && bus_addr[0] == nis_pkg::SEL_LINE
    |=> bus_rdata[2:0] == $past(pins_s[2:0])) else $error("line level mismatch");
  cond_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && addr_ok(bus_addr) && bus_addr[0] == nis_pkg::SEL_COND
    |=> bus_rdata[2:0] == $past(pins_s[2:0])) else $error("condition level mismatch");
  cond_live_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_rd && addr_ok(bus_addr) && bus_addr[0] == nis_pkg::SEL_COND
    |=> bus_rdata[6:5] == $past(pins_s[4:3])) else $error("condition live bits mismatch");
  // sticky flags: each event reaches every register, clears stay local
  dlk_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dlk_evt |=> flag_q[7][nis_pkg::BIT_DLK]) else $error("deadlock flag not set");
  flag_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    set_evt[15] |=> flag_q[9][15]) else $error("node flag not set");
  exp_second_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    set_evt[9] |=> flag_q[2][9]) else $error("second expansion flag not set");
  line_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_wr && bus_addr == 6'h00 && set_evt == 16'h0000 |=> flag_q[0] == $past(flag_q[0]))
    else $error("line write changed flags");
  group_apart_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bus_wr && bus_addr == 6'h01 && set_evt == 16'h0000 |=> flag_q[1] == $past(flag_q[1]))
    else $error("clear reached another group");
  any_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    |flag_q[4] |-> node_cond_any[1][1]) else $error("group output not raised");
  // timeout counter: one event per stalled access, idle clears the count
  tout_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tout_evt |=> !tout_evt) else $error("timeout event repeated");
  tout_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(pins_s[P_BUSY] && !pins_s[P_RDY]) |=> tcnt_q == '0) else $error("timeout count kept");
endmodule

// file: dv/nis_far_model.sv
// nis_far_model: backplane level, bridge error and shared bus slave timing.
// assumes bench commands change on the falling clock edge.
module nis_far_model (
  input wire logic sys_clk,
  input wire logic [2:0] req_level,
  input wire logic iack,
  input wire logic berr_set,
  input wire logic berr_clr,
  input wire logic [7:0] acc_len,
  output logic [2:0] backplane_level_field,
  output logic backplane_error_flag,
  output logic shared_bus_busy,
  output logic shared_bus_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial
  begin
    backplane_level_field = 3'h0;
    backplane_error_flag = 1'b0;
    shared_bus_busy = 1'b0;
    shared_bus_ready = 1'b0;
  end
  always @(posedge sys_clk)
  begin
    // a request level stays up until an acknowledge cycle takes it away
    if (iack)
      backplane_level_field <= 3'h0;
    else if (req_level != 3'h0)
      backplane_level_field <= req_level;
    // error held until the bridge side clears it
    if (berr_clr)
      backplane_error_flag <= 1'b0;
    else if (berr_set)
      backplane_error_flag <= 1'b1;
    // ready comes acc_len cycles after the start, slow or prompt
    if (shared_bus_ready)
    begin
      shared_bus_ready <= 1'b0;
      shared_bus_busy <= 1'b0;
    end
    else if (cnt == 1)
      shared_bus_ready <= 1'b1;
    else if (cnt == 0 && acc_len != 8'h00)
      shared_bus_busy <= 1'b1;
    cnt <= (cnt == 0) ? int'(acc_len) : cnt - 1;
  end
endmodule

// file: dv/tb_nis_top.sv
// tb_nis_top: register reads and writes checked against the source lines.
// assumes nis_top built with timeout counts of 20 and 40 cycles.
`define CHK(act, exp) \
  begin \
    n_tests++; \
    if ((act) !== (exp)) \
    begin \
      error_cnt++; \
      $display("[ERR] %0t got %h exp %h", $time, act, exp); \
    end \
  end
module tb_nis_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, bus_rd, bus_wr, bus_rvalid, iack, berr_set, berr_clr;
  logic [5:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic [2:0] req_level, backplane_level_field;
  logic [7:0] acc_len;
  logic bridge_chip_irq_n, location_monitor_line_n;
  logic expansion_line_first_n, expansion_line_second_n;
  logic [3:0] node_flag_line_n, node_vme_access;
  logic vme_shared_access, timeout_length_select, backplane_error_flag;
  logic shared_bus_busy, shared_bus_ready;
  logic [3:0][2:0] node_cond_any;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  nis_top #(.TOUT_SHORT(20), .TOUT_LONG(40)) dut (.sys_clk, .sys_rst, .bus_rd, .bus_wr,
    .bus_addr, .bus_wdata, .bus_rdata, .bus_rvalid, .backplane_level_field,
    .bridge_chip_irq_n, .location_monitor_line_n, .expansion_line_first_n,
    .expansion_line_second_n, .node_flag_line_n, .backplane_error_flag, .node_vme_access,
    .vme_shared_access, .shared_bus_busy, .shared_bus_ready, .timeout_length_select,
    .node_cond_any);
  nis_far_model far (.sys_clk, .req_level, .iack, .berr_set, .berr_clr, .acc_len,
    .backplane_level_field, .backplane_error_flag, .shared_bus_busy, .shared_bus_ready);
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard, far above the roughly 600 cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  function automatic logic [5:0] ad(input logic [1:0] n, input logic [1:0] g, input logic c);
    return {n, g, 1'b0, c};
  endfunction
  // pins pass a synchroniser, so give them time before looking
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    int k;
    @(negedge sys_clk);
    bus_rd = 1'b1;
    bus_addr = a;
    @(negedge sys_clk);
    bus_rd = 1'b0;
    k = 0;
    while (bus_rvalid !== 1'b1 && k < 4)
    begin
      @(negedge sys_clk);
      k++;
    end
    `CHK(bus_rvalid, 1'b1)
    `CHK(bus_rdata, {16'h0000, e})
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = {16'h0000, d};
    @(negedge sys_clk);
    bus_wr = 1'b0;
  endtask
  task automatic rd_all(input logic c, input logic [15:0] e);
    for (int n = 0; n < 4; n++)
      for (int g = 0; g < 3; g++)
        rd(ad(n[1:0], g[1:0], c), e);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  task automatic clr_all();
    for (int n = 0; n < 4; n++)
      for (int g = 0; g < 3; g++)
        wr(ad(n[1:0], g[1:0], 1'b1), 16'hFFFF);
  endtask
  task automatic access(input logic [7:0] n);
    acc_len = n;
    @(negedge sys_clk);
    acc_len = 8'h00;
    repeat (45) @(negedge sys_clk);
  endtask
  initial
  begin
    {bus_rd, bus_wr, iack, berr_set, berr_clr} = 5'h00;
    {vme_shared_access, timeout_length_select} = 2'h0;
    bus_addr = 6'h00;
    bus_wdata = 32'h0000_0000;
    req_level = 3'h0;
    acc_len = 8'h00;
    node_vme_access = 4'h0;
    {bridge_chip_irq_n, location_monitor_line_n} = 2'h3;
    {expansion_line_first_n, expansion_line_second_n} = 2'h3;
    node_flag_line_n = 4'hF;
    sys_rst = 1'b1;
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    settle();
    rd_all(1'b0, 16'h0000);
    rd_all(1'b1, 16'h0000);
    for (int v = 1; v < 8; v++)
    begin
      req_level = v[2:0];
      @(negedge sys_clk);
      req_level = 3'h0;
      settle();
      rd(ad(2'h2, 2'h1, 1'b0), 16'(v));
      wr(ad(2'h2, 2'h1, 1'b1), 16'h0007);
      rd(ad(2'h2, 2'h1, 1'b1), 16'(v));
      pulse(iack);
      settle();
      rd(ad(2'h2, 2'h1, 1'b1), 16'h0000);
    end
    {bridge_chip_irq_n, location_monitor_line_n} = 2'h0;
    {expansion_line_first_n, expansion_line_second_n} = 2'h0;
    node_flag_line_n = 4'h5;
    settle();
    rd_all(1'b0, 16'hA360);
    rd_all(1'b1, 16'hA360);
    `CHK(node_cond_any, 12'hFFF)
    {bridge_chip_irq_n, location_monitor_line_n} = 2'h3;
    {expansion_line_first_n, expansion_line_second_n} = 2'h3;
    node_flag_line_n = 4'hF;
    settle();
    rd_all(1'b0, 16'h0000);
    wr(ad(2'h0, 2'h0, 1'b1), 16'h0000);
    wr(ad(2'h0, 2'h0, 1'b0), 16'hFFFF);
    rd(ad(2'h0, 2'h0, 1'b0), 16'h0000);
    rd(ad(2'h0, 2'h0, 1'b1), 16'hA300);
    wr(ad(2'h0, 2'h0, 1'b1), 16'h2100);
    rd(ad(2'h0, 2'h0, 1'b1), 16'h8200);
    rd(ad(2'h1, 2'h0, 1'b1), 16'hA300);
    clr_all();
    rd_all(1'b1, 16'h0000);
    `CHK(node_cond_any, 12'h000)
    rd({2'h0, 2'h3, 2'h1}, 16'h0000);
    rd({2'h1, 2'h0, 2'h2}, 16'h0000);
    pulse(berr_set);
    settle();
    rd(ad(2'h3, 2'h2, 1'b1), 16'h0008);
    rd(ad(2'h3, 2'h2, 1'b0), 16'h0000);
    wr(ad(2'h3, 2'h2, 1'b1), 16'h0008);
    pulse(berr_clr);
    settle();
    rd(ad(2'h3, 2'h2, 1'b1), 16'h0000);
    clr_all();
    node_vme_access = 4'h4;
    settle();
    vme_shared_access = 1'b1;
    settle();
    rd(ad(2'h1, 2'h1, 1'b1), 16'h0010);
    node_vme_access = 4'h0;
    vme_shared_access = 1'b0;
    wr(ad(2'h1, 2'h1, 1'b1), 16'h0010);
    rd(ad(2'h1, 2'h1, 1'b1), 16'h0000);
    clr_all();
    access(8'd10);
    rd(ad(2'h0, 2'h2, 1'b1), 16'h0000);
    access(8'd30);
    rd(ad(2'h0, 2'h2, 1'b1), 16'h0800);
    wr(ad(2'h0, 2'h2, 1'b1), 16'h0800);
    timeout_length_select = 1'b1;
    settle();
    access(8'd30);
    rd(ad(2'h0, 2'h2, 1'b1), 16'h0000);
    end_of_test();
  end
endmodule
